// File: logic/lvsc_top.sv
`timescale 1ns/1ps

// overview of the datapath:
// - eight byte registers sit on the special function register port
// - a small image memory is reached only through the index and window
// - a second copy of the image feeds the glass, so a half-written
//   update never reaches the panel while the freeze bit is set
// - display gating and supply selection are plain decodes of the
//   registers, so they follow a write on the very next edge
// - no power state touches any register, so a dark panel comes back
//   with the same image when it is switched on again
// limitation: reads of unmapped addresses return zero, and a read
// always costs one enabled edge of latency
module lvsc_top #(
    parameter int MEM_DEPTH = 15
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // special function register port
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // power mode
    input wire logic battery_sleep_mode,
    // voltage generation and display
    output logic display_on,
    output logic pump_enable,
    output logic ladder_select,
    output logic [5:0] contrast_level,
    output logic image_frozen,
    output logic [3:0] mux_mode,
    // pin allocation and shown segment data
    output logic [28:0] segment_line_en,
    output logic [1:0] common_upper_en,
    output logic [7:0] shown_data [MEM_DEPTH]
);
    // software visible configuration registers
    logic [7:0] main_ff, nxt_main;
    logic [7:0] seg_lo_ff, nxt_seg_lo;
    logic [7:0] cfgx_ff, nxt_cfgx;
    logic [7:0] cfgy_ff, nxt_cfgy;
    logic [7:0] seg_hi_ff, nxt_seg_hi;
    logic [7:0] peripheral_config_ff, nxt_peripheral_config;
    // indirect access pair into the image memory
    logic [7:0] index_ff, nxt_index;
    logic [7:0] window_ff, nxt_window;
    // image memory as written, and the copy that the panel shows
    logic [7:0] mem_ff [MEM_DEPTH];
    logic [7:0] nxt_mem [MEM_DEPTH];
    logic [7:0] shown_ff [MEM_DEPTH];
    logic [7:0] nxt_shown [MEM_DEPTH];
    // registered read data
    logic [7:0] rd_ff, nxt_rd;
    // decoded display and multiplex state
    logic enable_bit;
    logic awake_on;
    logic sleep_on;
    logic four_mux;

    // write strobe aimed at one address; clock enable is applied at the
    // registers, so a write seen while frozen is simply dropped
    function automatic logic hit(input logic [7:0] a);
        return sfr_wr && (sfr_addr == a);
    endfunction

    // register writes; only software writes change state, so nothing is
    // lost when the display goes dark
    always_comb begin
        nxt_main = hit(lvsc_pkg::ADDR_MAIN_CONFIG) ? sfr_wdata : main_ff;
        nxt_seg_lo = hit(lvsc_pkg::ADDR_SEG_EN_LOW) ? sfr_wdata : seg_lo_ff;
        nxt_cfgx = hit(lvsc_pkg::ADDR_CONFIG_X) ? sfr_wdata : cfgx_ff;
        nxt_cfgy = hit(lvsc_pkg::ADDR_CONFIG_Y) ? sfr_wdata : cfgy_ff;
        nxt_seg_hi = hit(lvsc_pkg::ADDR_SEG_EN_HIGH) ? sfr_wdata : seg_hi_ff;
        nxt_peripheral_config = hit(lvsc_pkg::ADDR_PERIPHERAL_CONFIG) ? sfr_wdata : peripheral_config_ff;
        nxt_index = hit(lvsc_pkg::ADDR_INDEX) ? sfr_wdata : index_ff;
        nxt_window = window_ff;
        nxt_mem = mem_ff;
        if (hit(lvsc_pkg::ADDR_WINDOW_DATA)) begin
            nxt_window = sfr_wdata;
        end
        // indirect access through the index register; an index beyond
        // the memory is kept in the register but moves no data, which
        // keeps the low address bits from aliasing onto a real byte
        if (hit(lvsc_pkg::ADDR_INDEX) && (sfr_wdata[6:0] < 7'(MEM_DEPTH))) begin
            if (sfr_wdata[lvsc_pkg::BIT_INDEX_WRITE]) begin
                nxt_mem[sfr_wdata[3:0]] = window_ff;
            end else begin
                nxt_window = mem_ff[sfr_wdata[3:0]];
            end
        end
        // image copy stalls while frozen, so partial updates never show
        nxt_shown = cfgy_ff[lvsc_pkg::BIT_FREEZE] ? shown_ff : mem_ff;
    end

    // read mux, registered for one cycle of latency; the register
    // costs a cycle but keeps the address decode off the read path
    // of the core
    always_comb begin
        case (sfr_addr)
            lvsc_pkg::ADDR_MAIN_CONFIG: nxt_rd = main_ff;
            lvsc_pkg::ADDR_SEG_EN_LOW: nxt_rd = seg_lo_ff;
            lvsc_pkg::ADDR_CONFIG_X: nxt_rd = cfgx_ff;
            lvsc_pkg::ADDR_CONFIG_Y: nxt_rd = cfgy_ff;
            lvsc_pkg::ADDR_SEG_EN_HIGH: nxt_rd = seg_hi_ff;
            lvsc_pkg::ADDR_PERIPHERAL_CONFIG: nxt_rd = peripheral_config_ff;
            lvsc_pkg::ADDR_INDEX: nxt_rd = index_ff;
            lvsc_pkg::ADDR_WINDOW_DATA: nxt_rd = window_ff;
            default: nxt_rd = lvsc_pkg::RST_REG;
        endcase
    end

    // state registers, frozen by clock enable; reset wins over the
    // enable so the block comes up clean even with the clock gated
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_ff <= lvsc_pkg::RST_REG;
            seg_lo_ff <= lvsc_pkg::RST_REG;
            cfgx_ff <= lvsc_pkg::RST_REG;
            cfgy_ff <= lvsc_pkg::RST_REG;
            seg_hi_ff <= lvsc_pkg::RST_REG;
            peripheral_config_ff <= lvsc_pkg::RST_REG;
            index_ff <= lvsc_pkg::RST_REG;
            window_ff <= lvsc_pkg::RST_REG;
            rd_ff <= lvsc_pkg::RST_REG;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_ff[i] <= lvsc_pkg::RST_REG;
                shown_ff[i] <= lvsc_pkg::RST_REG;
            end
        end else if (clk_en) begin
            main_ff <= nxt_main;
            seg_lo_ff <= nxt_seg_lo;
            cfgx_ff <= nxt_cfgx;
            cfgy_ff <= nxt_cfgy;
            seg_hi_ff <= nxt_seg_hi;
            peripheral_config_ff <= nxt_peripheral_config;
            index_ff <= nxt_index;
            window_ff <= nxt_window;
            rd_ff <= nxt_rd;
            // image memory and shown copy
            mem_ff <= nxt_mem;
            shown_ff <= nxt_shown;
        end
    end

    // display gating: awake the enable bit alone decides, asleep the
    // inhibit bit and the reference enable must agree as well; the
    // reference bit is a software duty, so the panel stays dark when
    // it is forgotten rather than running on a missing reference
    assign enable_bit = main_ff[lvsc_pkg::BIT_DISPLAY_ENABLE];
    assign awake_on = enable_bit;
    assign sleep_on = enable_bit && !main_ff[lvsc_pkg::BIT_SLEEP_INHIBIT]
        && peripheral_config_ff[lvsc_pkg::BIT_REF_IN_SLEEP];
    assign display_on = battery_sleep_mode ? sleep_on : awake_on;

    // voltage source; pump idles when dark to save battery
    assign ladder_select = cfgx_ff[lvsc_pkg::BIT_LADDER_SELECT];
    assign pump_enable = display_on && !ladder_select;
    // contrast only meaningful with the pump, so zero it for the ladder
    assign contrast_level = ladder_select ? 6'h00 :
        cfgx_ff[lvsc_pkg::CONTRAST_LSB +: lvsc_pkg::CONTRAST_W];
    // status and data outputs straight from registers
    assign image_frozen = cfgy_ff[lvsc_pkg::BIT_FREEZE];
    assign sfr_rdata = rd_ff;
    assign shown_data = shown_ff;

    // multiplex decode: one-hot count of active commons minus one;
    // in four-way multiplex the two shared pins are taken as commons
    // and their segment enables are overruled further down
    assign four_mux = main_ff[lvsc_pkg::MUX_LSB +: lvsc_pkg::MUX_W] == lvsc_pkg::MUX_FOUR;
    assign mux_mode = 4'h1 << main_ff[lvsc_pkg::MUX_LSB +: lvsc_pkg::MUX_W];
    assign common_upper_en = four_mux ? 2'h3 : 2'h0;

    // segment pin allocation: the low sixteen lines need no enable,
    // the next eight follow the low enable register, and the top five
    // follow the high one; the shared pair also yields to the commons
    genvar g;
    generate
        for (g = 0; g < lvsc_pkg::TOTAL_SEGS; g++) begin : g_seg
            if (g < lvsc_pkg::FIXED_SEGS) begin : g_fixed
                assign segment_line_en[g] = 1'b1;
            end else if (g < lvsc_pkg::FIXED_SEGS + 8) begin : g_low
                assign segment_line_en[g] = seg_lo_ff[g - lvsc_pkg::FIXED_SEGS];
            end else if (g == lvsc_pkg::SHARED_COM3_SEG || g == lvsc_pkg::SHARED_COM2_SEG) begin : g_sh
                assign segment_line_en[g] = seg_hi_ff[g - lvsc_pkg::FIXED_SEGS - 8]
                    && !four_mux;
            end else begin : g_high
                assign segment_line_en[g] = seg_hi_ff[g - lvsc_pkg::FIXED_SEGS - 8];
            end
        end
    endgenerate
endmodule // lvsc_top

// File: logic/lvsc_pkg.sv
package lvsc_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_MAIN_CONFIG = 8'h95;
    localparam logic [7:0] ADDR_SEG_EN_LOW = 8'h97;
    localparam logic [7:0] ADDR_CONFIG_X = 8'h9c;
    localparam logic [7:0] ADDR_INDEX = 8'hac;
    localparam logic [7:0] ADDR_WINDOW_DATA = 8'hae;
    localparam logic [7:0] ADDR_CONFIG_Y = 8'hb1;
    localparam logic [7:0] ADDR_SEG_EN_HIGH = 8'hed;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG = 8'hf4;
    // field positions
    localparam int BIT_DISPLAY_ENABLE = 7;
    localparam int BIT_SLEEP_INHIBIT = 4;
    localparam int BIT_LADDER_SELECT = 6;
    localparam int BIT_REF_IN_SLEEP = 3;
    localparam int BIT_FREEZE = 0;
    localparam int BIT_INDEX_WRITE = 7;
    localparam int CONTRAST_LSB = 0;
    localparam int CONTRAST_W = 6;
    localparam int MUX_LSB = 0;
    localparam int MUX_W = 2;
    localparam logic [1:0] MUX_FOUR = 2'h3;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // segment layout
    localparam int FIXED_SEGS = 16;
    localparam int TOTAL_SEGS = 29;
    localparam int SHARED_COM3_SEG = 27;
    localparam int SHARED_COM2_SEG = 28;
endpackage

// File: tb/lvsc_monitor.sv
`timescale 1ns/1ps
module lvsc_monitor (
    // watched top-level ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic battery_sleep_mode,
    input wire logic display_on,
    input wire logic pump_enable,
    input wire logic ladder_select,
    input wire logic [5:0] contrast_level,
    input wire logic [28:0] segment_line_en,
    input wire logic [1:0] common_upper_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a register write taken on an enabled edge
    sequence wr_s(logic [7:0] a);
        clk_en && sfr_wr && sfr_addr == a;
    endsequence
    // supply, pins, then effects of writes one edge later
    a_pump_gate: assert property (pump_enable == (display_on && !ladder_select))
        else $error("pump enable wrong");
    a_ladder_mute: assert property (ladder_select |-> contrast_level == 6'h00)
        else $error("contrast not muted");
    a_fixed_segs: assert property (segment_line_en[15:0] == 16'hffff)
        else $error("low segment lines off");
    a_shared_commons: assert property (common_upper_en == 2'h3 |->
        segment_line_en[28:27] == 2'h0) else $error("shared pin as segment");
    a_ladder_write: assert property (wr_s(8'h9c) |=>
        ladder_select == $past(sfr_wdata[6])) else $error("ladder bit not taken");
    a_awake_enable: assert property (wr_s(8'h95) ##0 !battery_sleep_mode |=>
        battery_sleep_mode || display_on == $past(sfr_wdata[7])) else $error("awake display");
    a_sleep_inhibit: assert property (wr_s(8'h95) ##0 sfr_wdata[4] |=>
        !battery_sleep_mode || !display_on) else $error("inhibit ignored");
    a_sleep_ref: assert property (wr_s(8'hf4) ##0 !sfr_wdata[3] |=>
        !battery_sleep_mode || !display_on) else $error("reference ignored");
endmodule // lvsc_monitor
bind lvsc_top lvsc_monitor mon (.*);

// File: tb/lvsc_glass.sv
`timescale 1ns/1ps
module lvsc_glass (
    // drive from the controller, and what a viewer sees
    input wire logic display_on,
    input wire logic [7:0] seg_byte,
    output logic [7:0] lit
);
    // an unpowered panel shows nothing, whatever memory holds
    assign lit = display_on ? seg_byte : 8'h00;
endmodule // lvsc_glass

// File: tb/lvsc_test.sv
`timescale 1ns/1ps
module lvsc_test;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sfr_wr = 1'b0, battery_sleep_mode = 1'b0;
    logic display_on, pump_enable, ladder_select, image_frozen;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, lit, c, s;
    logic [5:0] contrast_level;
    logic [3:0] mux_mode;
    logic [28:0] segment_line_en;
    logic [1:0] common_upper_en;
    logic [7:0] shown_data [15];
    int fail_count = 0, n_compared = 0;
    // 8 ns clock
    always #4 ref_clk = ~ref_clk;
    lvsc_top dut (.*);
    lvsc_glass glass (.display_on(display_on), .seg_byte(shown_data[13]), .lit(lit));
    // compare and count; access leaves read data of its address settled
    task automatic chk(string n, logic [28:0] e, logic [28:0] g);
        n_compared++;
        fail_count += (g !== e);
        if (g !== e)
            $display("Error %s expected %h seen %h", n, e, g);
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        sfr_wr <= w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // voltage, sleep gating, then pins and image memory
    initial begin
        void'($urandom(50445));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        c = 8'($urandom_range(46));
        acc(1, 8'h95, 8'h80);
        acc(1, 8'h9c, c);
        chk("contrast", c, contrast_level);
        chk("pump on", 1, pump_enable);
        acc(1, 8'h9c, c | 8'h40);
        chk("muted contrast", 0, contrast_level);
        chk("pump", 0, pump_enable);
        // a write while the clock enable is low must leave state alone
        @(posedge ref_clk);
        clk_en <= 1'b0;
        acc(1, 8'h9c, c);
        chk("enable freeze", 1, ladder_select);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        $display("voltage test done");
        // sleep held through the loop so the monitor sees it too
        @(posedge ref_clk);
        battery_sleep_mode <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            acc(1, 8'hf4, {4'h0, i[0], 3'h0});
            acc(1, 8'h95, {i[2], 2'h0, i[1], 4'h0});
            chk("sleep display", i[2] & ~i[1] & i[0], display_on);
        end
        @(posedge ref_clk);
        battery_sleep_mode <= 1'b0;
        #1 chk("awake display", 1, display_on);
        // the refresh divider lives in the clock block; here it is unmapped
        acc(1, 8'h96, 8'h0f);
        acc(0, 8'h96, 8'h00);
        chk("unmapped read", 0, sfr_rdata);
        $display("sleep test done");
        s = 8'($urandom);
        acc(1, 8'h97, s);
        acc(1, 8'hed, 8'h1f);
        acc(1, 8'h95, 8'h03);
        chk("segments", {5'h07, s, 16'hffff}, segment_line_en);
        chk("commons", 3, common_upper_en);
        chk("mux mode", 4'h8, mux_mode);
        acc(1, 8'hb1, 8'h01);
        chk("freeze flag", 1, image_frozen);
        acc(1, 8'hae, 8'hf0);
        acc(1, 8'hac, 8'h8d);
        chk("frozen image", 0, shown_data[13]);
        acc(1, 8'hb1, 8'h00);
        acc(1, 8'h95, 8'h83);
        chk("shown image", 8'hf0, lit);
        acc(1, 8'hac, 8'h0d);
        acc(0, 8'hae, 8'h00);
        chk("window read", 8'hf0, sfr_rdata);
        $display("memory test done");
        stop_test();
    end
endmodule // lvsc_test
